// ===== verilog/rss_regs.svh
// Constants for the rotate, power-down and subtract execute block.
// Assumes a 14-bit instruction word and an 8-bit data path.
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH
`define RSS_OPC_ROTATE_LEFT  6'h0d
`define RSS_OPC_FILE_SUB     6'h02
`define RSS_OPC_LIT_SUB      5'h1e
`define RSS_POWERDOWN_WORD   14'h0063
`define RSS_OPC_HI           13
`define RSS_OPC_LO           8
`define RSS_DEST_BIT         7
`define RSS_ADDR_HI          6
`define RSS_WDT_CLEAR        8'h00
`define RSS_ACC_RESET        8'h00
`define RSS_STATUS_RESET     5'h03
`endif

// ===== verilog/rss_pkg.sv
// Types shared by the rotate, power-down and subtract execute block.
// Assumes nothing beyond the constants header.
package rss_pkg;
  typedef struct packed {
    logic carry;
    logic digit_carry_flag;
    logic zero;
    logic timeout_flag_n;
    logic powerdown_flag_n;
  } rss_status_type;

  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } rss_file_wr_type;
endpackage

// ===== verilog/rss_exec.sv
// Execute logic for rotate-left-through-carry, power-down and two subtracts.
// Assumes file read data is valid in the same cycle as the instruction word.
//
// Notes on behaviour
// - Opcode 001101 rotates file register left; carry into bit 0, bit 7 out.
// - Rotate result goes to accumulator if dest 0, else back to file.
// - Power-down clears the watchdog counter and its prescaler.
// - Power-down sets timeout flag_n to 1, clears powerdown flag_n to 0.
// - After power-down, enter halt and request oscillator stop.
// - Opcode 11110x computes literal minus accumulator into accumulator.
// - Subtracts set carry when result is non-negative, clear it when negative.
// - Opcode 000010 computes file register minus accumulator.
// - File subtract stores to accumulator if dest 0, else back to file.
`timescale 1ns/10ps
`include "rss_regs.svh"
module rss_exec (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  // Instruction
  input  wire logic                 instr_valid,
  input  wire logic [13:0]          instr_word,
  // File register path
  input  wire logic [7:0]           file_rd_data,
  output logic [6:0]                file_rd_addr,
  output rss_pkg::rss_file_wr_type  file_wr,
  // Core state
  output logic [7:0]                acc,
  output rss_pkg::rss_status_type   status,
  // Power control
  output logic                      wdt_clear,
  output logic                      prescaler_clear,
  output logic                      halted,
  output logic                      osc_stop_req
);
  import rss_pkg::*;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic [5:0] opc;
  logic       dest;
  logic       is_rot;
  logic       is_fsub;
  logic       is_lsub;
  logic       is_pd;
  logic [7:0] sub_a;
  logic [8:0] diff;
  logic [4:0] low_diff;
  logic [7:0] acc_q, acc_d;

  assign opc          = instr_word[`RSS_OPC_HI:`RSS_OPC_LO];
  assign dest         = instr_word[`RSS_DEST_BIT];
  assign file_rd_addr = instr_word[`RSS_ADDR_HI:0];
  assign is_rot  = instr_valid && !halted && opc == `RSS_OPC_ROTATE_LEFT;
  assign is_fsub = instr_valid && !halted && opc == `RSS_OPC_FILE_SUB;
  assign is_lsub = instr_valid && !halted && opc[5:1] == `RSS_OPC_LIT_SUB;
  assign is_pd   = instr_valid && !halted && instr_word == `RSS_POWERDOWN_WORD;

  // Borrow-free subtract: a + ~w + 1, carry out means no borrow
  assign sub_a    = is_lsub ? instr_word[7:0] : file_rd_data;
  assign diff     = {1'b0, sub_a} + {1'b0, ~acc_q} + 9'h001;
  assign low_diff = {1'b0, sub_a[3:0]} + {1'b0, ~acc_q[3:0]} + 5'h01;

  // ----------------------------------------
  // State
  // ----------------------------------------
  rss_status_type  st_q, st_d;
  rss_file_wr_type wr_q, wr_d;
  logic            halt_q, halt_d;
  logic            wclr_q, wclr_d;
  logic [7:0]      result;

  always_comb begin
    acc_d   = acc_q;
    st_d    = st_q;
    halt_d  = halt_q;
    wclr_d  = 1'b0;
    wr_d    = '0;
    result  = 8'h00;
    if (is_rot) begin
      result     = {file_rd_data[6:0], st_q.carry};
      st_d.carry = file_rd_data[7];
    end else if (is_fsub || is_lsub) begin
      result                = diff[7:0];
      st_d.carry            = diff[8];
      st_d.digit_carry_flag = low_diff[4];
      st_d.zero             = diff[7:0] == 8'h00;
    end
    if (is_lsub) begin
      acc_d = result;
    end else if (is_rot || is_fsub) begin
      if (dest) begin
        wr_d.we   = 1'b1;
        wr_d.addr = instr_word[`RSS_ADDR_HI:0];
        wr_d.data = result;
      end else begin
        acc_d = result;
      end
    end
    if (is_pd) begin
      wclr_d                = 1'b1;
      st_d.timeout_flag_n   = 1'b1;
      st_d.powerdown_flag_n = 1'b0;
      halt_d                = 1'b1;
    end
  end

  // Single-cycle commit; wake-up lies outside this block, so halt only clears on reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_q  <= `RSS_ACC_RESET;
      st_q   <= `RSS_STATUS_RESET;
      wr_q   <= '0;
      halt_q <= 1'b0;
      wclr_q <= 1'b0;
    end else begin
      acc_q  <= acc_d;
      st_q   <= st_d;
      wr_q   <= wr_d;
      halt_q <= halt_d;
      wclr_q <= wclr_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign acc             = acc_q;
  assign status          = st_q;
  assign file_wr         = wr_q;
  assign halted          = halt_q;
  assign osc_stop_req    = halt_q;
  assign wdt_clear       = wclr_q;
  assign prescaler_clear = wclr_q;
endmodule

// ===== bench/rss_exec_checker.sv
// Port assertions for the execute block.
// Assumes it is bound to rss_exec.
`timescale 1ns/10ps
module rss_exec_checker import rss_pkg::*; (
  input logic            sys_clk, reset_n, instr_valid, wdt_clear,
  input logic            prescaler_clear, halted, osc_stop_req,
  input logic [13:0]     instr_word,
  input logic [7:0]      file_rd_data, acc,
  input logic [6:0]      file_rd_addr,
  input rss_file_wr_type file_wr,
  input rss_status_type  status
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire       go  = instr_valid && !halted;
  wire       lit = go && instr_word[13:9] == 5'h1e;
  wire       fs  = go && instr_word[13:8] == 6'h02;
  wire       rl  = go && instr_word[13:8] == 6'h0d;
  wire       pd  = go && instr_word == 14'h0063;
  wire [7:0] op  = instr_word[13] ? instr_word[7:0] : file_rd_data;
  wire [7:0] dif = op - acc;
  wire [7:0] rot = {file_rd_data[6:0], status.carry};
  wire [7:0] res = file_wr.we ? file_wr.data : acc;
  a_rot_carry: assert property (rl |=> status.carry == $past(file_rd_data[7]))
    else $error("rotate carry");
  a_rot_dest: assert property (rl |=> res == $past(rot) && file_wr.we == $past(instr_word[7]))
    else $error("rotate result");
  a_sleep_clr: assert property (pd |=> wdt_clear && prescaler_clear)
    else $error("sleep clear");
  a_sleep_flags: assert property (pd |=> status.timeout_flag_n && !status.powerdown_flag_n
    && status.carry == $past(status.carry)) else $error("sleep flags");
  a_halt_osc: assert property (pd |=> halted && osc_stop_req)
    else $error("sleep halt");
  a_lit_result: assert property (lit |=> acc == $past(dif))
    else $error("literal diff");
  a_sub_carry: assert property (lit || fs |=> status.carry == ($past(op) >= $past(acc)))
    else $error("sub carry");
  a_file_dest: assert property (fs |=> res == $past(dif) && file_wr.we == $past(instr_word[7]))
    else $error("file diff");
  a_sub_zero_dc: assert property (lit || fs |=> status.zero == ($past(dif) == 8'h00)
    && status.digit_carry_flag == ($past(op[3:0]) >= $past(acc[3:0]))) else $error("sub flags");
  a_file_addr: assert property (fs |-> file_rd_addr == instr_word[6:0])
    else $error("file address");
endmodule
bind rss_exec rss_exec_checker i_chk (.*);

// ===== bench/rss_fmem.sv
// File register model: combinational read, write on the pulse.
// Assumes contents start at address plus 8'h70.
`timescale 1ns/10ps
module rss_fmem import rss_pkg::*; (
  input logic            clk,
  input logic [6:0]      ra,
  input rss_file_wr_type wr,
  output logic [7:0]     rd
);
  logic [7:0] m [128];
  initial for (int i = 0; i < 128; i++) m[i] = 8'(i) + 8'h70;
  assign rd = m[ra];
  always @(posedge clk) if (wr.we) m[wr.addr] <= wr.data;
endmodule

// ===== bench/tb_rotate_sleep_subtract_ops.sv
// Bench for the execute block against the file register model.
// Assumes a one-cycle answer to every instruction.
`timescale 1ns/10ps
module tb_rotate_sleep_subtract_ops;
  import rss_pkg::*;
  logic            sys_clk = 0, reset_n = 0, instr_valid = 0, wc, pc, hl, os;
  logic [13:0]     instr_word = 14'h0000;
  logic [7:0]      rd, acc;
  logic [6:0]      ra;
  rss_file_wr_type wr;
  rss_status_type  st;
  int              n_errors = 0, total_checks = 0;
  always #25 sys_clk = ~sys_clk;
  rss_exec i_dut (.sys_clk, .reset_n, .instr_valid, .instr_word, .file_rd_data(rd),
    .file_rd_addr(ra), .file_wr(wr), .acc, .status(st), .wdt_clear(wc),
    .prescaler_clear(pc), .halted(hl), .osc_stop_req(os));
  rss_fmem i_mem (.clk(sys_clk), .ra, .wr, .rd);
  task chk(input logic [7:0] g, e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task run(input logic [13:0] w);
    @(posedge sys_clk) instr_valid <= 1;
    instr_word <= w;
    @(posedge sys_clk) instr_valid <= 0;
    @(negedge sys_clk);
  endtask
  task t_rot;
    run(14'h0d85); chk(wr.data, 8'hea); chk(st.carry, 0); chk(wr.we, 1);
    run(14'h0d05); chk(acc, 8'hd4); chk(st.carry, 1);
    run(14'h0d05); chk(acc, 8'hd5); chk(i_mem.m[5], 8'hea);
    $display("rotate test done");
  endtask
  task t_sub;
    run(14'h3d01); chk(acc, 8'h2c); chk(st.carry, 0);
    run(14'h3c2c); chk(acc, 8'h00); chk(st, 5'h1f);
    run(14'h3c02); chk(acc, 8'h02);
    run(14'h0201); chk(acc, 8'h6f); chk(st, 5'h13);
    run(14'h0280); chk(wr.data, 8'h01); chk(wr.addr, 8'h00);
    $display("subtract test done");
  endtask
  task t_sleep;
    run(14'h0063); chk({wc, pc, hl, os}, 8'h0f); chk(st, 5'h12);
    run(14'h3c55); chk(acc, 8'h6f); chk(wc, 0);
    $display("sleep test done");
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1;
    t_rot;
    t_sub;
    t_sleep;
    give_verdict;
  end
endmodule
